/* File: verif/rcf_top_bench.sv */
// Purpose: directed bench for reset causes and flags
// Assumes: zero-wait slave, read data taken at the edge that ends the data phase
// Notes: short qualify and soft delay counts keep the run brief
`timescale 1ns/10ps
module rcf_top_bench;
	logic mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans, power_mode;
	logic [2:0] hsize;
	logic supply_low, external_reset_pin_n, wdt_timeout, wdt_ctrl_bad, halt_enter, wdt_clear;
	logic core_pc_sp_clear, core_full_reset, core_acc_tblp_reset, timers_off, ints_off;
	logic wdt_timebase_clear, port_init_load, ctrl_reg_load, timeout_flag, power_down_flag;
	logic external_reset_pin_en;
	logic [7:0] port_data_init, watchdog_control_register, reset_select_register;
	int n_fail = 0, total_checks = 0, n_full = 0, n_pcsp = 0, n_port = 0, cyc = 0;
	int n_acc = 0, n_ctrl = 0;
	int f0, q0, p0;
	assign hready = hreadyout;
	rcf_top #(.LV_QCYC(8), .SOFT_CYC(4)) dut_u (.*);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task test_done();
		if (n_fail == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : test_done
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge mclk);
	endtask : tick
	task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task rdc(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(rd, {24'h00_0000, e});
	endtask : rdc
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (core_full_reset === 1'b1)
			n_full <= n_full + 1;
		if (core_pc_sp_clear === 1'b1)
			n_pcsp <= n_pcsp + 1;
		if (port_init_load === 1'b1)
			n_port <= n_port + 1;
		if (core_acc_tblp_reset === 1'b1)
			n_acc <= n_acc + 1;
		if (ctrl_reg_load === 1'b1)
			n_ctrl <= n_ctrl + 1;
		if (cyc == 3000) begin
			n_fail++;
			test_done();
		end
	end
	initial begin
		rst = 1'b1;
		{hsel, hwrite, supply_low, wdt_timeout, wdt_ctrl_bad, halt_enter, wdt_clear} = 7'h00;
		external_reset_pin_n = 1'b1;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		htrans = 2'b00;
		hsize = 3'b010;
		power_mode = rcf_pkg::RCF_MODE_FAST;
		tick(16);
		rst <= 1'b0;
		tick(4);
		rdc(8'h00, 8'h00);
		rdc(8'h04, 8'h55);
		rdc(8'h08, 8'h53);
		rdc(8'h0C, 8'h00);
		chk(port_data_init, 32'h0000_00FF);
		chk(hresp, 1'b0);
		f0 = n_full;
		supply_low <= 1'b1;
		tick(4);
		supply_low <= 1'b0;
		tick(20);
		chk(n_full - f0, 0);
		rdc(8'h00, 8'h00);
		halt_enter <= 1'b1;
		tick(1);
		halt_enter <= 1'b0;
		f0 = n_full;
		supply_low <= 1'b1;
		tick(20);
		supply_low <= 1'b0;
		tick(8);
		chk(n_full != f0, 1);
		rdc(8'h00, 8'h04);
		rdc(8'h0C, 8'h02);
		f0 = n_full;
		p0 = n_port;
		wdt_timeout <= 1'b1;
		tick(1);
		wdt_timeout <= 1'b0;
		tick(4);
		chk(n_full - f0, 1);
		chk(n_port - p0, 1);
		rdc(8'h0C, 8'h03);
		rdc(8'h00, 8'h04);
		bus(1'b1, 8'h00, 8'hFF);
		rdc(8'h00, 8'h04);
		bus(1'b1, 8'h00, 8'h00);
		rdc(8'h00, 8'h00);
		bus(1'b1, 8'h04, 8'hAA);
		power_mode <= rcf_pkg::RCF_MODE_SLEEP;
		f0 = n_full;
		q0 = n_pcsp;
		p0 = n_port;
		supply_low <= 1'b1;
		tick(30);
		supply_low <= 1'b0;
		wdt_clear <= 1'b1;
		tick(1);
		wdt_clear <= 1'b0;
		wdt_timeout <= 1'b1;
		tick(1);
		wdt_timeout <= 1'b0;
		tick(4);
		chk(n_full - f0, 0);
		chk(n_pcsp - q0, 1);
		chk(n_port - p0, 0);
		rdc(8'h00, 8'h00);
		rdc(8'h0C, 8'h03);
		rdc(8'h04, 8'hAA);
		chk(external_reset_pin_en, 1'b1);
		rdc(8'h10, 8'hFF);
		power_mode <= rcf_pkg::RCF_MODE_SLOW;
		tick(2);
		f0 = n_full;
		external_reset_pin_n <= 1'b0;
		tick(6);
		external_reset_pin_n <= 1'b1;
		tick(6);
		chk(n_full != f0, 1);
		rdc(8'h0C, 8'h03);
		rdc(8'h04, 8'h55);
		chk(external_reset_pin_en, 1'b0);
		f0 = n_full;
		bus(1'b1, 8'h04, 8'h12);
		tick(12);
		chk(n_full - f0, 1);
		rdc(8'h00, 8'h08);
		bus(1'b1, 8'h00, 8'h00);
		wdt_clear <= 1'b1;
		tick(1);
		wdt_clear <= 1'b0;
		f0 = n_full;
		wdt_timeout <= 1'b1;
		wdt_ctrl_bad <= 1'b1;
		tick(1);
		wdt_timeout <= 1'b0;
		wdt_ctrl_bad <= 1'b0;
		tick(4);
		chk(n_full - f0, 1);
		chk(timeout_flag, 1);
		chk(power_down_flag, 0);
		rdc(8'h00, 8'h01);
		rst <= 1'b1;
		tick(2);
		rst <= 1'b0;
		tick(4);
		rdc(8'h0C, 8'h00);
		rdc(8'h00, 8'h00);
		chk(n_acc, 2);
		chk(n_ctrl, 7);
		test_done();
	end
endmodule : rcf_top_bench

/* File: verif/rcf_top_properties.sv */
// Purpose: timing checks on reset sources and their effects
// Assumes: single mclk domain, rst active high
// Notes: the low-power watchdog check assumes no other source in that cycle
`timescale 1ns/10ps
module rcf_top_properties (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// sources
	input wire logic external_reset_pin_n,
	input wire logic wdt_timeout,
	input wire logic wdt_ctrl_bad,
	input wire logic [1:0] power_mode,
	input wire logic halt_enter,
	input wire logic wdt_clear,
	// effects
	input wire logic core_pc_sp_clear,
	input wire logic core_full_reset,
	input wire logic timers_off,
	input wire logic ints_off,
	input wire logic wdt_timebase_clear,
	input wire logic [7:0] port_data_init,
	input wire logic port_init_load,
	input wire logic timeout_flag,
	input wire logic power_down_flag,
	input wire logic [7:0] watchdog_control_register,
	input wire logic [7:0] reset_select_register,
	// bus
	input wire logic [31:0] hrdata
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	// power_mode bit 1 marks idle and sleep
	sequence s_wd_lp;
		wdt_timeout && power_mode[1] && !wdt_ctrl_bad && !halt_enter && !wdt_clear && external_reset_pin_n;
	endsequence
	sequence s_wd_norm;
		wdt_timeout && !power_mode[1];
	endsequence
	sequence s_pcsp_only;
		##1 core_pc_sp_clear && !core_full_reset && !port_init_load;
	endsequence
	a_wd_lp_partial: assert property (s_wd_lp |-> s_pcsp_only)
		else $error("low-power timeout did more than pc and sp clear");
	a_wd_lp_flags: assert property (s_wd_lp |-> ##[1:2] (timeout_flag && power_down_flag))
		else $error("low-power timeout left a status flag clear");
	a_wd_norm_full: assert property (s_wd_norm |=> core_full_reset && port_init_load)
		else $error("normal timeout gave no full reset");
	a_wd_norm_to: assert property (s_wd_norm |-> ##[1:2] timeout_flag)
		else $error("normal timeout left timeout flag clear");
	a_ports_all_ones: assert property (port_init_load |-> ##[0:1] port_data_init == 8'hFF)
		else $error("port init value not all ones");
	a_full_reload: assert property (core_full_reset |-> ##[0:1]
		(watchdog_control_register == 8'h53 && reset_select_register == 8'h55))
		else $error("full reset did not reload control values");
	a_por_effects: assert property ($fell(rst) |-> ##[1:3]
		(timers_off && ints_off && wdt_timebase_clear && core_pc_sp_clear))
		else $error("power-on effects missing");
	a_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
		else $error("unimplemented read bits not zero");
endmodule : rcf_top_properties

bind rcf_top rcf_top_properties u_chk (.*);

/* File: verilog/rcf_defs.svh */
// Purpose: constants for the reset cause and initial condition block
// Assumes: 32-bit AHB-Lite register words, 250 MHz mclk
// Notes: qualify and soft reset delays are nominal
`ifndef RCF_DEFS_SVH
`define RCF_DEFS_SVH
`define RCF_OFF_CAUSE 12'h000
`define RCF_OFF_SELECT 12'h004
`define RCF_OFF_WDCTRL 12'h008
`define RCF_OFF_STATUS 12'h00C
`define RCF_OFF_CTRL 12'h010
`define RCF_BIT_RSTCTRL 3
`define RCF_BIT_LOWV 2
`define RCF_BIT_WDCTRL 0
`define RCF_CAUSE_MASK 8'h0D
`define RCF_SEL_RESET 8'h55
`define RCF_SEL_PIN 8'hAA
`define RCF_WD_RESET 8'h53
`define RCF_WD_EN 5'h0A
`define RCF_WD_DIS 5'h15
`define RCF_CTRL_RESET 8'h00
`define RCF_PORT_RESET 8'hFF
`define RCF_CLK_MHZ 250
`define RCF_LV_QUALIFY_US 120
`define RCF_LV_QUALIFY_CYC (`RCF_LV_QUALIFY_US * `RCF_CLK_MHZ)
`define RCF_SOFT_DELAY_NS 100
`define RCF_SOFT_DELAY_CYC ((`RCF_SOFT_DELAY_NS * `RCF_CLK_MHZ) / 1000)
`endif

/* File: verilog/rcf_pkg.sv */
// Purpose: types for the reset cause block
// Assumes: nothing
// Notes: reset kinds ordered from narrowest to broadest
package rcf_pkg;
	typedef enum logic [1:0] {
		RCF_MODE_FAST = 2'b00,
		RCF_MODE_SLOW = 2'b01,
		RCF_MODE_IDLE = 2'b11,
		RCF_MODE_SLEEP = 2'b10
	} rcf_mode_t;
	typedef enum logic [2:0] {
		RCF_RK_NONE = 3'b000,
		RCF_RK_WARM = 3'b001,
		RCF_RK_WDOG = 3'b011,
		RCF_RK_FULL = 3'b010,
		RCF_RK_POWER = 3'b110
	} rcf_kind_t;
endpackage : rcf_pkg

/* File: verilog/rcf_qual.sv */
// Purpose: low supply qualification timer
// Assumes: synchronised low supply level
// Notes: pulse once the level has lasted for the qualify count
`timescale 1ns/10ps
module rcf_qual #(
	parameter int QCYC = 30000
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// control
	input wire logic enable,
	input wire logic low_in,
	output logic fire
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	logic fire_reg;
	logic fire_next;
	always_comb begin
		cnt_next = 32'h0000_0000;
		fire_next = 1'b0;
		// a dip shorter than the count restarts the timer and never fires
		if (enable && low_in) begin
			if (cnt_reg < 32'(QCYC))
				cnt_next = cnt_reg + 32'h0000_0001;
			else
				cnt_next = cnt_reg;
			fire_next = (cnt_reg == 32'(QCYC) - 32'h0000_0001);
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_reg <= 32'h0000_0000;
			fire_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			fire_reg <= fire_next;
		end
	end
	assign fire = fire_reg;
endmodule : rcf_qual

/* File: verilog/rcf_sync.sv */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: asynchronous input level
// Notes: output changes only once stages two and three agree
`timescale 1ns/10ps
module rcf_sync #(
	parameter logic INIT = 1'b0
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// data
	input wire logic din,
	output logic dout
);
	logic [2:0] stg_reg;
	logic [2:0] stg_next;
	logic out_reg;
	logic out_next;
	always_comb begin
		stg_next = {stg_reg[1:0], din};
		out_next = (stg_reg[1] == stg_reg[2]) ? stg_reg[2] : out_reg;
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			stg_reg <= {3{INIT}};
			out_reg <= INIT;
		end else begin
			stg_reg <= stg_next;
			out_reg <= out_next;
		end
	end
	assign dout = out_reg;
endmodule : rcf_sync

/* File: verilog/rcf_top.sv */
// Purpose: reset source handling, cause flags and initial conditions
// Assumes: rst is the power-on reset; ahb-lite single word accesses
// Notes: core sees one-cycle reset pulses per kind
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "rcf_defs.svh"
module rcf_top #(
	parameter int LV_QCYC = `RCF_LV_QUALIFY_CYC,
	parameter int SOFT_CYC = `RCF_SOFT_DELAY_CYC
) (
	// clock and power-on reset
	input wire logic mclk,
	input wire logic rst,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// sources
	input wire logic supply_low,
	input wire logic external_reset_pin_n,
	input wire logic wdt_timeout,
	input wire logic wdt_ctrl_bad,
	input wire logic [1:0] power_mode,
	input wire logic halt_enter,
	input wire logic wdt_clear,
	// reset effects
	output logic core_pc_sp_clear,
	output logic core_full_reset,
	output logic core_acc_tblp_reset,
	output logic timers_off,
	output logic ints_off,
	output logic wdt_timebase_clear,
	output logic [7:0] port_data_init,
	output logic port_init_load,
	output logic ctrl_reg_load,
	output logic timeout_flag,
	output logic power_down_flag,
	output logic [7:0] watchdog_control_register,
	output logic [7:0] reset_select_register,
	output logic external_reset_pin_en
);
	// only bits 3, 2 and 0 of the cause register exist
	localparam logic [7:0] CAUSE_MASK = `RCF_CAUSE_MASK;
	rcf_pkg::rcf_mode_t mode;
	logic sleep_mode;
	logic pin_n_s;
	logic supply_low_s;
	logic lv_fire;
	logic pin_fire;
	logic wdt_norm;
	logic wdt_sleep;
	logic soft_fire;
	rcf_pkg::rcf_kind_t kind;
	logic por_seen_reg;
	logic por_seen_next;
	logic pin_n_prev_reg;
	logic pin_n_prev_next;
	logic [7:0] cause_reg;
	logic [7:0] cause_next;
	logic [7:0] sel_reg;
	logic [7:0] sel_next;
	logic [7:0] wdc_reg;
	logic [7:0] wdc_next;
	logic to_reg;
	logic to_next;
	logic pdf_reg;
	logic pdf_next;
	logic [15:0] soft_cnt_reg;
	logic [15:0] soft_cnt_next;
	logic soft_pend_reg;
	logic soft_pend_next;
	logic [6:0] pulse_reg;
	logic [6:0] pulse_next;
	logic [7:0] port_reg;
	logic [7:0] port_next;
	logic dph_wr_reg;
	logic dph_wr_next;
	logic pin_en_reg;
	logic pin_en_next;
	logic [11:0] dph_addr_reg;
	logic [11:0] dph_addr_next;
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic [7:0] wbyte;
	assign mode = rcf_pkg::rcf_mode_t'(power_mode);
	assign sleep_mode = (mode == rcf_pkg::RCF_MODE_IDLE) || (mode == rcf_pkg::RCF_MODE_SLEEP);
	// the pin and the comparator are not on mclk, so both pass three stages
	rcf_sync #(.INIT(1'b1)) u_pin_sync (
		.mclk(mclk),
		.rst(rst),
		.din(external_reset_pin_n),
		.dout(pin_n_s)
	);
	rcf_sync #(.INIT(1'b0)) u_lv_sync (
		.mclk(mclk),
		.rst(rst),
		.din(supply_low),
		.dout(supply_low_s)
	);
	// monitor has no enable bit, only the power mode gates it
	rcf_qual #(.QCYC(LV_QCYC)) u_lv_qual (
		.mclk(mclk),
		.rst(rst),
		.enable(~sleep_mode),
		.low_in(supply_low_s),
		.fire(lv_fire)
	);
	// pin reset only when the select register routes the pin to reset
	assign pin_fire = (sel_reg == `RCF_SEL_PIN) && pin_n_prev_reg && !pin_n_s;
	// the edge detector idles high like the pin, so no false edge follows reset
	assign wdt_norm = wdt_timeout && !sleep_mode;
	assign wdt_sleep = wdt_timeout && sleep_mode;
	assign soft_fire = soft_pend_reg && (soft_cnt_reg == 16'h0000);
	assign wbyte = hwdata[7:0];
	// pick the broadest kind present
	// the first edge after rst is released is taken as the power-on reset
	always_comb begin
		if (!por_seen_reg)
			kind = rcf_pkg::RCF_RK_POWER;
		else if (lv_fire || pin_fire || wdt_norm || soft_fire || wdt_ctrl_bad)
			kind = rcf_pkg::RCF_RK_FULL;
		else if (wdt_sleep)
			kind = rcf_pkg::RCF_RK_WDOG;
		else
			kind = rcf_pkg::RCF_RK_NONE;
	end
	always_comb begin
		por_seen_next = 1'b1;
		pin_n_prev_next = pin_n_s;
		cause_next = cause_reg;
		sel_next = sel_reg;
		wdc_next = wdc_reg;
		to_next = to_reg;
		pdf_next = pdf_reg;
		soft_cnt_next = soft_cnt_reg;
		soft_pend_next = soft_pend_reg;
		port_next = port_reg;
		pulse_next = 7'h00;
		dph_wr_next = 1'b0;
		dph_addr_next = dph_addr_reg;
		rdata_next = rdata_reg;
		// power-down flag follows halt and watchdog clear
		if (halt_enter) begin
			pdf_next = 1'b1;
			to_next = 1'b0;
		end
		if (wdt_clear) begin
			pdf_next = 1'b0;
			to_next = 1'b0;
		end
		// count down before the write decode so a fresh bad pattern reloads the delay
		if (soft_pend_reg && soft_cnt_reg != 16'h0000)
			soft_cnt_next = soft_cnt_reg - 16'h0001;
		// software writes first so hardware sets win over clears
		if (dph_wr_reg) begin
			unique case (dph_addr_reg)
				`RCF_OFF_CAUSE: cause_next = cause_reg & wbyte & CAUSE_MASK;
				`RCF_OFF_SELECT: begin
					sel_next = wbyte;
					if (wbyte != `RCF_SEL_RESET && wbyte != `RCF_SEL_PIN) begin
						soft_pend_next = 1'b1;
						soft_cnt_next = 16'(SOFT_CYC);
					end
				end
				`RCF_OFF_WDCTRL: wdc_next = wbyte;
				default: ;
			endcase
		end
		if (soft_fire)
			cause_next[`RCF_BIT_RSTCTRL] = 1'b1;
		if (lv_fire)
			cause_next[`RCF_BIT_LOWV] = 1'b1;
		if (wdt_ctrl_bad)
			cause_next[`RCF_BIT_WDCTRL] = 1'b1;
		unique case (kind)
			rcf_pkg::RCF_RK_POWER: begin
				cause_next = 8'h00; // flag stays unknown-ish: held at zero
				to_next = 1'b0;
				pdf_next = 1'b0;
				pulse_next = 7'h7F;
				port_next = `RCF_PORT_RESET;
			end
			rcf_pkg::RCF_RK_FULL: begin
				// cause flags survive every reset except power-on
				if (wdt_timeout)
					to_next = 1'b1;
				// a sleep timeout merged into a broader reset still marks power-down
				if (wdt_sleep)
					pdf_next = 1'b1;
				pulse_next = 7'h7B; // acc and table pointer kept
				port_next = `RCF_PORT_RESET;
			end
			rcf_pkg::RCF_RK_WDOG: begin
				// warm reset: ports, controls and cause flags keep their values
				to_next = 1'b1;
				pdf_next = 1'b1;
				pulse_next = 7'h01;
			end
			default: ;
		endcase
		// a pending soft delay is dropped by any broader reset that lands first
		if (kind == rcf_pkg::RCF_RK_POWER || kind == rcf_pkg::RCF_RK_FULL) begin
			sel_next = `RCF_SEL_RESET;
			wdc_next = `RCF_WD_RESET;
			soft_pend_next = 1'b0;
			soft_cnt_next = 16'h0000;
		end
		// registered so the pin enable output comes straight from a flop
		pin_en_next = (sel_next == `RCF_SEL_PIN);
		// ahb address phase; read data is captured from the next-state values here,
		// so it stands for the whole data phase and already shows a write ending with it
		if (hsel && hready && htrans[1]) begin
			dph_wr_next = hwrite;
			dph_addr_next = haddr[11:0];
			if (!hwrite) begin
				unique case (haddr[11:0])
					`RCF_OFF_CAUSE: rdata_next = {24'h00_0000, cause_next & CAUSE_MASK};
					`RCF_OFF_SELECT: rdata_next = {24'h00_0000, sel_next};
					`RCF_OFF_WDCTRL: rdata_next = {24'h00_0000, wdc_next};
					`RCF_OFF_STATUS: rdata_next = {30'h0000_0000, pdf_next, to_next};
					`RCF_OFF_CTRL: rdata_next = {24'h00_0000, port_next};
					default: rdata_next = 32'h0000_0000;
				endcase
			end
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			por_seen_reg <= 1'b0;
			pin_n_prev_reg <= 1'b1;
			cause_reg <= 8'h00;
			sel_reg <= `RCF_SEL_RESET;
			wdc_reg <= `RCF_WD_RESET;
			to_reg <= 1'b0;
			pdf_reg <= 1'b0;
			soft_cnt_reg <= 16'h0000;
			soft_pend_reg <= 1'b0;
			pulse_reg <= 7'h00;
			port_reg <= `RCF_PORT_RESET;
			dph_wr_reg <= 1'b0;
			pin_en_reg <= 1'b0;
			dph_addr_reg <= 12'h000;
			rdata_reg <= 32'h0000_0000;
		end else begin
			por_seen_reg <= por_seen_next;
			pin_n_prev_reg <= pin_n_prev_next;
			cause_reg <= cause_next;
			sel_reg <= sel_next;
			wdc_reg <= wdc_next;
			to_reg <= to_next;
			pdf_reg <= pdf_next;
			soft_cnt_reg <= soft_cnt_next;
			soft_pend_reg <= soft_pend_next;
			pulse_reg <= pulse_next;
			port_reg <= port_next;
			dph_wr_reg <= dph_wr_next;
			pin_en_reg <= pin_en_next;
			dph_addr_reg <= dph_addr_next;
			rdata_reg <= rdata_next;
		end
	end
	// pulse bits: 0 pc/sp, 1 full, 2 acc/tblp, 3 timers, 4 ints, 5 wdt, 6 ports and controls
	assign core_pc_sp_clear = pulse_reg[0];
	assign core_full_reset = pulse_reg[1];
	assign core_acc_tblp_reset = pulse_reg[2];
	assign timers_off = pulse_reg[3];
	assign ints_off = pulse_reg[4];
	assign wdt_timebase_clear = pulse_reg[5];
	assign port_init_load = pulse_reg[6];
	assign ctrl_reg_load = pulse_reg[6];
	assign port_data_init = port_reg;
	assign timeout_flag = to_reg;
	assign power_down_flag = pdf_reg;
	assign watchdog_control_register = wdc_reg;
	assign reset_select_register = sel_reg;
	assign external_reset_pin_en = pin_en_reg;
	// zero wait states: every transfer completes in its first data phase cycle
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_reg;
endmodule : rcf_top
